// >>> verif/cdm_host_model.sv
// Register bus host model that drives command, data and strobes
`timescale 1ns/1ps
module cdm_host_model (
   input wire logic clock_in,
   input wire cdm_pkg::cdm_byte_t rdata_in,
   output logic [7:0] addr_out,
   output cdm_pkg::cdm_byte_t wdata_out,
   output logic wr_out,
   output logic rd_out
);
   import cdm_pkg::*;
   initial begin
      addr_out = 8'hFF;
      wdata_out = 8'h00;
      wr_out = 1'b0;
      rd_out = 1'b0;
   end
   // Called just after an edge; a pending strobe drop costs one edge so it is never rewritten
   task automatic wr_reg(input logic [7:0] a, input cdm_byte_t d);
      if (wr_out) begin
         @(posedge clock_in);
      end
      addr_out <= a;
      wdata_out <= d;
      wr_out <= 1'b1;
      @(posedge clock_in);
      wr_out <= 1'b0;
      wdata_out <= ~d;
   endtask
   // Data is taken at the edge that closes the answer cycle, before it returns to zero
   task automatic rd_reg(input logic [7:0] a, output cdm_byte_t d);
      addr_out <= a;
      rd_out <= 1'b1;
      @(posedge clock_in);
      rd_out <= 1'b0;
      @(posedge clock_in);
      d = rdata_in;
   endtask
endmodule // cdm_host_model

// >>> verif/cdm_top_assertions.sv
// Concurrent checks on the ports of the critical output mask block
`timescale 1ns/1ps
module cdm_top_checker (
   input wire logic clock_in,
   input wire logic resetn_in,
   input wire logic [7:0] addr_in,
   input wire cdm_pkg::cdm_byte_t wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire cdm_pkg::cdm_byte_t rdata_out,
   input wire logic conv_done_in,
   input wire cdm_pkg::cdm_byte_t local_temp_in,
   input wire cdm_pkg::cdm_byte_t rem1_temp_in,
   input wire cdm_pkg::cdm_byte_t rem2_temp_in,
   input wire cdm_pkg::cdm_byte_t rem3_temp_in,
   input wire cdm_pkg::cdm_byte_t rem4_temp_in,
   input wire cdm_pkg::cdm_rem_t beta_comp_on_in,
   input wire cdm_pkg::cdm_rem_t std_diode_seen_in,
   input wire logic crit_out_first_n_out,
   input wire logic crit_out_second_n_out,
   input wire logic crit_out_third_n_out,
   input wire logic irq_out
);
   import cdm_pkg::*;
   default clocking @(posedge clock_in);
   endclocking
   default disable iff (!resetn_in);
   a_rd_idle_zero: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
      else $error("read data not zero outside a read");
   a_mask_reserved_zero: assert property ($past(rd_in) &&
      $past(addr_in) inside {8'h0C, 8'h0D, 8'h0E} |-> rdata_out[7:5] == 3'h0)
      else $error("mask reserved bits not zero");
   a_mask_read_back: assert property (
      wr_in && addr_in inside {8'h0C, 8'h0D, 8'h0E}
      ##1 rd_in && addr_in == $past(addr_in) |=> rdata_out[4:0] == $past(wdata_in[4:0], 2))
      else $error("mask read after write differs");
   a_diode_flag_value: assert property (
      $past(rd_in) && $past(addr_in) == 8'h38
      |-> rdata_out == {3'h0, $past(beta_comp_on_in & std_diode_seen_in, 2), 1'b0})
      else $error("diode flags wrong");
   a_first_fall_cause: assert property ($fell(crit_out_first_n_out)
      |-> $past(conv_done_in, 2) || $past(wr_in, 2))
      else $error("first pin fell without cause");
   a_second_rise_cause: assert property ($rose(crit_out_second_n_out)
      |-> $past(conv_done_in, 2) || $past(wr_in, 2))
      else $error("second pin rose without cause");
   a_third_change_cause: assert property ($changed(crit_out_third_n_out)
      |-> $past(conv_done_in, 2) || $past(wr_in, 2))
      else $error("third pin changed without cause");
   a_pins_idle_release: assert property ($rose(resetn_in)
      |-> crit_out_first_n_out && crit_out_second_n_out && crit_out_third_n_out)
      else $error("pin active right after reset");
   a_irq_masked_low: assert property (wr_in && addr_in == 8'h71 && wdata_in[3:0] == 4'hF
      |=> !irq_out)
      else $error("interrupt high with all sources masked");
endmodule // cdm_top_checker
bind cdm_top cdm_top_checker u_cdm_top_checker (.clock_in, .resetn_in, .addr_in, .wdata_in,
   .wr_in, .rd_in, .rdata_out, .conv_done_in, .local_temp_in, .rem1_temp_in, .rem2_temp_in,
   .rem3_temp_in, .rem4_temp_in, .beta_comp_on_in, .std_diode_seen_in, .crit_out_first_n_out,
   .crit_out_second_n_out, .crit_out_third_n_out, .irq_out);

// >>> verif/cdm_top_tb_top.sv
// Self-checking bench for the critical output mask block
`timescale 1ns/1ps
module cdm_top_tb_top;
   import cdm_pkg::*;
   logic clock_in = 1'b0;
   logic resetn_in = 1'b0;
   logic conv_done_in = 1'b0;
   logic [39:0] temps = 40'h0;
   cdm_rem_t beta = 4'h0;
   cdm_rem_t std_seen = 4'h0;
   logic [7:0] addr_in;
   cdm_byte_t wdata_in, rdata_out, rv;
   logic wr_in, rd_in, irq_out;
   logic [2:0] pins_n;
   int mismatches = 0, num_checks = 0;
   logic [7:0] addrs [5] = '{8'h0C, 8'h0D, 8'h0E, 8'h38, 8'h20};
   logic [7:0] resets [5] = '{8'h19, 8'h00, 8'h07, 8'h00, 8'h00};
   always #2 clock_in = ~clock_in;
   cdm_host_model u_cdm_host_model (.clock_in, .rdata_in(rdata_out), .addr_out(addr_in),
      .wdata_out(wdata_in), .wr_out(wr_in), .rd_out(rd_in));
   cdm_top u_cdm_top (.clock_in, .resetn_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
      .conv_done_in, .local_temp_in(temps[7:0]), .rem1_temp_in(temps[15:8]),
      .rem2_temp_in(temps[23:16]), .rem3_temp_in(temps[31:24]), .rem4_temp_in(temps[39:32]),
      .beta_comp_on_in(beta), .std_diode_seen_in(std_seen), .crit_out_first_n_out(pins_n[0]),
      .crit_out_second_n_out(pins_n[1]), .crit_out_third_n_out(pins_n[2]), .irq_out);
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      u_cdm_host_model.rd_reg(a, rv);
      check(rv, exp);
   endtask
   // One conversion result, all five readings at once
   task automatic conv(input logic [39:0] t);
      conv_done_in <= 1'b1;
      temps <= t;
      @(posedge clock_in);
      conv_done_in <= 1'b0;
   endtask
   // Pins settle one edge after the conversion or mask write is taken; the check waits two edges
   task automatic pins_chk(input logic [2:0] exp);
      repeat (2) @(posedge clock_in);
      check({5'h00, pins_n}, {5'h00, exp});
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge clock_in);
      mismatches++;
      wrap_up();
   end
   initial begin
      repeat (4) @(posedge clock_in);
      resetn_in <= 1'b1;
      @(posedge clock_in);
      for (int i = 0; i < 5; i++) begin
         rd_chk(addrs[i], resets[i]);
      end
      rd_chk(8'h41, 8'h6E);
      rd_chk(8'h49, 8'h55);
      u_cdm_host_model.wr_reg(8'h40, 8'hFF);
      rd_chk(8'h40, 8'h7F);
      u_cdm_host_model.wr_reg(8'h40, 8'h55);
      u_cdm_host_model.wr_reg(8'h5A, 8'hFF);
      rd_chk(8'h5A, 8'h1F);
      u_cdm_host_model.wr_reg(8'h5A, 8'h0A);
      for (int i = 0; i < 3; i++) begin
         u_cdm_host_model.wr_reg(addrs[i], 8'hFF);
         rd_chk(addrs[i], 8'h1F);
         u_cdm_host_model.wr_reg(addrs[i], resets[i]);
      end
      $display("test registers done");
      beta <= 4'hB;
      std_seen <= 4'h6;
      repeat (2) @(posedge clock_in);
      rd_chk(8'h38, 8'h04);
      std_seen <= 4'h0;
      repeat (2) @(posedge clock_in);
      rd_chk(8'h38, 8'h00);
      $display("test diode flags done");
      conv(40'h60);
      pins_chk(3'b101);
      u_cdm_host_model.wr_reg(8'h0D, 8'h01);
      pins_chk(3'b111);
      u_cdm_host_model.wr_reg(8'h0D, 8'h00);
      pins_chk(3'b101);
      conv(40'h4B);
      pins_chk(3'b101);
      conv(40'h4A);
      pins_chk(3'b111);
      conv(40'h55_0000_0000);
      pins_chk(3'b001);
      conv(40'h6000);
      pins_chk(3'b101);
      // Remote 1 at its first-pin limit is one of two default paths to the first pin, with remote 2
      conv(40'h6E00);
      pins_chk(3'b100);
      $display("test pins done");
      check({7'h00, irq_out}, 8'h00);
      u_cdm_host_model.wr_reg(8'h71, 8'h00);
      @(posedge clock_in);
      check({7'h00, irq_out}, 8'h01);
      rd_chk(8'h70, 8'h0F);
      u_cdm_host_model.wr_reg(8'h70, 8'h0F);
      @(posedge clock_in);
      check({7'h00, irq_out}, 8'h00);
      rd_chk(8'h70, 8'h00);
      u_cdm_host_model.wr_reg(8'h71, 8'h0F);
      // A new mismatch sets its sticky bit, but the full mask keeps the line low
      std_seen <= 4'h1;
      repeat (2) @(posedge clock_in);
      check({7'h00, irq_out}, 8'h00);
      rd_chk(8'h70, 8'h08);
      rd_chk(8'h38, 8'h02);
      $display("test interrupt done");
      wrap_up();
   end
endmodule // cdm_top_tb_top

// >>> verilog/cdm_crit_status.sv
// One channel status bit with set at limit and clear below limit minus hysteresis
`timescale 1ns/1ps
module cdm_crit_status (
   input wire logic clock_in,
   input wire logic resetn_in,
   input wire logic update_in,
   input wire logic [7:0] reading_in,
   input wire logic [7:0] limit_in,
   input wire logic [4:0] hyst_in,
   output logic status_out
);
   logic status_reg;
   logic [8:0] clear_level;
   // Nine bits keep limit minus hysteresis from wrapping below zero
   assign clear_level = {1'b0, limit_in} - {4'h0, hyst_in};
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         status_reg <= 1'b0;
      end else if (update_in) begin
         if (reading_in >= limit_in) begin
            status_reg <= 1'b1;
         end else if (!clear_level[8] && ({1'b0, reading_in} < clear_level)) begin
            status_reg <= 1'b0;
         end
      end
   end
   assign status_out = status_reg;
endmodule // cdm_crit_status

// >>> verilog/cdm_defs.svh
// Command codes, field layouts, reset values and widths of the critical output mask block
`ifndef CDM_DEFS_SVH
`define CDM_DEFS_SVH
`define CDM_CMD_MASK1 8'h0C
`define CDM_CMD_MASK2 8'h0D
`define CDM_CMD_MASK3 8'h0E
`define CDM_CMD_DIODE 8'h38
`define CDM_CMD_LIM_LOCAL 8'h40
`define CDM_CMD_LIM_R1_1 8'h41
`define CDM_CMD_LIM_R2_1 8'h42
`define CDM_CMD_LIM_R3 8'h43
`define CDM_CMD_LIM_R4 8'h44
`define CDM_CMD_LIM_R1_2 8'h49
`define CDM_CMD_LIM_R2_2 8'h4A
`define CDM_CMD_HYST 8'h5A
`define CDM_CMD_IRQ_STAT 8'h70
`define CDM_CMD_IRQ_MASK 8'h71
`define CDM_RST_MASK1 5'h19
`define CDM_RST_MASK2 5'h00
`define CDM_RST_MASK3 5'h07
`define CDM_RST_LIM_LOCAL 7'h55
`define CDM_RST_LIM_R12_1 8'h6E
`define CDM_RST_LIM_OTHER 8'h55
`define CDM_RST_HYST 5'h0A
`define CDM_RST_IRQ_MASK 4'hF
`define CDM_CHANS 5
`define CDM_PINS 3
`define CDM_REMS 4
`define CDM_IRQS 4
`define CDM_IRQ_DIODE 3
`endif

// >>> verilog/cdm_pkg.sv
// Shared types of the critical output mask block
package cdm_pkg;
   typedef logic [7:0] cdm_byte_t;
   typedef logic [4:0] cdm_chan_t;
   typedef logic [3:0] cdm_rem_t;
endpackage

// >>> verilog/cdm_top.sv
// Critical output masking, channel status and diode mismatch flags with register port
//
// Function
// - First mask at 0x0C resets 0x19
// - Second mask at 0x0D resets 0x00
// - Third mask at 0x0E resets 0x07
// - Clear mask bit forwards channel event
// - Reserved bits read as zero
// - Diode flag per remote channel at 0x38
// - Flag reads zero without mismatch
// - Pin active while any unmasked status set
// - Status sets at limit, clears below hysteresis
`timescale 1ns/1ps
`include "cdm_defs.svh"
module cdm_top (
   input wire logic clock_in,
   input wire logic resetn_in,
   input wire logic [7:0] addr_in,
   input wire cdm_pkg::cdm_byte_t wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output cdm_pkg::cdm_byte_t rdata_out,
   input wire logic conv_done_in,
   input wire cdm_pkg::cdm_byte_t local_temp_in,
   input wire cdm_pkg::cdm_byte_t rem1_temp_in,
   input wire cdm_pkg::cdm_byte_t rem2_temp_in,
   input wire cdm_pkg::cdm_byte_t rem3_temp_in,
   input wire cdm_pkg::cdm_byte_t rem4_temp_in,
   input wire cdm_pkg::cdm_rem_t beta_comp_on_in,
   input wire cdm_pkg::cdm_rem_t std_diode_seen_in,
   output logic crit_out_first_n_out,
   output logic crit_out_second_n_out,
   output logic crit_out_third_n_out,
   output logic irq_out
);
   import cdm_pkg::*;

   // Mask registers, bit 0 local then remotes 1 to 4
   cdm_chan_t mask_reg [0:`CDM_PINS-1];
   logic [6:0] lim_local_reg;
   cdm_byte_t lim_r1_first_reg;
   cdm_byte_t lim_r2_first_reg;
   cdm_byte_t lim_r3_reg;
   cdm_byte_t lim_r4_reg;
   cdm_byte_t lim_r1_second_reg;
   cdm_byte_t lim_r2_second_reg;
   logic [4:0] hyst_reg;
   cdm_rem_t diode_flag_reg;
   cdm_rem_t diode_flag_next;
   logic [`CDM_IRQS-1:0] irq_stat_reg;
   logic [`CDM_IRQS-1:0] irq_stat_next;
   logic [`CDM_IRQS-1:0] irq_mask_reg;
   logic [`CDM_IRQS-1:0] irq_event;
   logic [`CDM_PINS-1:0] pin_active_next;
   logic [`CDM_PINS-1:0] pin_n_reg;
   cdm_byte_t rdata_reg;
   cdm_byte_t rdata_next;
   cdm_byte_t chan_temp [0:`CDM_CHANS-1];
   cdm_byte_t chan_limit [0:`CDM_PINS-1][0:`CDM_CHANS-1];
   cdm_chan_t chan_status [0:`CDM_PINS-1];

   // True when a write strobe addresses the given command
   function automatic logic wr_hit(input logic wr, input logic [7:0] addr,
                                   input logic [7:0] cmd);
      wr_hit = wr && (addr == cmd);
   endfunction

   // Pin stays active while any status bit is set and not blocked
   function automatic logic pin_active(input cdm_chan_t status, input cdm_chan_t mask);
      pin_active = |(status & ~mask);
   endfunction

   // Mask registers
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         mask_reg[0] <= `CDM_RST_MASK1;
         mask_reg[1] <= `CDM_RST_MASK2;
         mask_reg[2] <= `CDM_RST_MASK3;
      end else begin
         if (wr_hit(wr_in, addr_in, `CDM_CMD_MASK1)) begin
            mask_reg[0] <= wdata_in[4:0];
         end
         if (wr_hit(wr_in, addr_in, `CDM_CMD_MASK2)) begin
            mask_reg[1] <= wdata_in[4:0];
         end
         if (wr_hit(wr_in, addr_in, `CDM_CMD_MASK3)) begin
            mask_reg[2] <= wdata_in[4:0];
         end
      end
   end

   // Limit and hysteresis registers
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         lim_local_reg <= `CDM_RST_LIM_LOCAL;
         lim_r1_first_reg <= `CDM_RST_LIM_R12_1;
         lim_r2_first_reg <= `CDM_RST_LIM_R12_1;
         lim_r3_reg <= `CDM_RST_LIM_OTHER;
         lim_r4_reg <= `CDM_RST_LIM_OTHER;
         lim_r1_second_reg <= `CDM_RST_LIM_OTHER;
         lim_r2_second_reg <= `CDM_RST_LIM_OTHER;
         hyst_reg <= `CDM_RST_HYST;
      end else begin
         if (wr_hit(wr_in, addr_in, `CDM_CMD_LIM_LOCAL)) begin
            lim_local_reg <= wdata_in[6:0];
         end
         if (wr_hit(wr_in, addr_in, `CDM_CMD_LIM_R1_1)) begin
            lim_r1_first_reg <= wdata_in;
         end
         if (wr_hit(wr_in, addr_in, `CDM_CMD_LIM_R2_1)) begin
            lim_r2_first_reg <= wdata_in;
         end
         if (wr_hit(wr_in, addr_in, `CDM_CMD_LIM_R3)) begin
            lim_r3_reg <= wdata_in;
         end
         if (wr_hit(wr_in, addr_in, `CDM_CMD_LIM_R4)) begin
            lim_r4_reg <= wdata_in;
         end
         if (wr_hit(wr_in, addr_in, `CDM_CMD_LIM_R1_2)) begin
            lim_r1_second_reg <= wdata_in;
         end
         if (wr_hit(wr_in, addr_in, `CDM_CMD_LIM_R2_2)) begin
            lim_r2_second_reg <= wdata_in;
         end
         if (wr_hit(wr_in, addr_in, `CDM_CMD_HYST)) begin
            hyst_reg <= wdata_in[4:0];
         end
      end
   end

   assign chan_temp[0] = local_temp_in;
   assign chan_temp[1] = rem1_temp_in;
   assign chan_temp[2] = rem2_temp_in;
   assign chan_temp[3] = rem3_temp_in;
   assign chan_temp[4] = rem4_temp_in;

   // Remotes 1 and 2 use their second limit for the second and third pins
   always_comb begin
      for (int p = 0; p < `CDM_PINS; p++) begin
         chan_limit[p][0] = {1'b0, lim_local_reg};
         chan_limit[p][1] = (p == 0) ? lim_r1_first_reg : lim_r1_second_reg;
         chan_limit[p][2] = (p == 0) ? lim_r2_first_reg : lim_r2_second_reg;
         chan_limit[p][3] = lim_r3_reg;
         chan_limit[p][4] = lim_r4_reg;
      end
   end

   // Status bits update only on conversion results, never on register writes
   generate
      for (genvar p = 0; p < `CDM_PINS; p++) begin : g_pin
         for (genvar c = 0; c < `CDM_CHANS; c++) begin : g_chan
            cdm_crit_status u_status (
               .clock_in(clock_in),
               .resetn_in(resetn_in),
               .update_in(conv_done_in),
               .reading_in(chan_temp[c]),
               .limit_in(chan_limit[p][c]),
               .hyst_in(hyst_reg),
               .status_out(chan_status[p][c])
            );
         end
      end
   endgenerate

   // Pin evaluation every cycle so a new mask is seen on the next edge
   always_comb begin
      for (int p = 0; p < `CDM_PINS; p++) begin
         pin_active_next[p] = pin_active(chan_status[p], mask_reg[p]);
      end
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pin_n_reg <= '1;
      end else begin
         pin_n_reg <= ~pin_active_next;
      end
   end

   assign crit_out_first_n_out = pin_n_reg[0];
   assign crit_out_second_n_out = pin_n_reg[1];
   assign crit_out_third_n_out = pin_n_reg[2];

   // Flag is a live copy of the mismatch, so it falls back to zero once cured
   assign diode_flag_next = beta_comp_on_in & std_diode_seen_in;

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         diode_flag_reg <= '0;
      end else begin
         diode_flag_reg <= diode_flag_next;
      end
   end

   // Events: a pin turning active, or a new diode mismatch appearing
   always_comb begin
      irq_event[`CDM_PINS-1:0] = pin_active_next & pin_n_reg;
      irq_event[`CDM_IRQ_DIODE] = |(diode_flag_next & ~diode_flag_reg);
   end

   // Sticky status, write one to clear; a same-cycle event wins
   always_comb begin
      irq_stat_next = irq_stat_reg;
      if (wr_hit(wr_in, addr_in, `CDM_CMD_IRQ_STAT)) begin
         irq_stat_next = irq_stat_reg & ~wdata_in[`CDM_IRQS-1:0];
      end
      irq_stat_next = irq_stat_next | irq_event;
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         irq_stat_reg <= '0;
      end else begin
         irq_stat_reg <= irq_stat_next;
      end
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         irq_mask_reg <= `CDM_RST_IRQ_MASK;
      end else if (wr_hit(wr_in, addr_in, `CDM_CMD_IRQ_MASK)) begin
         irq_mask_reg <= wdata_in[`CDM_IRQS-1:0];
      end
   end

   // Mask bit set keeps its sticky bit off the line, in the same sense as the pin masks
   assign irq_out = |(irq_stat_reg & ~irq_mask_reg);

   // Read decode; unmapped commands and reserved bits return zero
   always_comb begin
      rdata_next = '0;
      case (addr_in)
         `CDM_CMD_MASK1: begin
            rdata_next = {3'h0, mask_reg[0]};
         end
         `CDM_CMD_MASK2: begin
            rdata_next = {3'h0, mask_reg[1]};
         end
         `CDM_CMD_MASK3: begin
            rdata_next = {3'h0, mask_reg[2]};
         end
         `CDM_CMD_DIODE: begin
            rdata_next = {3'h0, diode_flag_reg, 1'b0};
         end
         `CDM_CMD_LIM_LOCAL: begin
            rdata_next = {1'b0, lim_local_reg};
         end
         `CDM_CMD_LIM_R1_1: begin
            rdata_next = lim_r1_first_reg;
         end
         `CDM_CMD_LIM_R2_1: begin
            rdata_next = lim_r2_first_reg;
         end
         `CDM_CMD_LIM_R3: begin
            rdata_next = lim_r3_reg;
         end
         `CDM_CMD_LIM_R4: begin
            rdata_next = lim_r4_reg;
         end
         `CDM_CMD_LIM_R1_2: begin
            rdata_next = lim_r1_second_reg;
         end
         `CDM_CMD_LIM_R2_2: begin
            rdata_next = lim_r2_second_reg;
         end
         `CDM_CMD_HYST: begin
            rdata_next = {3'h0, hyst_reg};
         end
         `CDM_CMD_IRQ_STAT: begin
            rdata_next = {4'h0, irq_stat_reg};
         end
         `CDM_CMD_IRQ_MASK: begin
            rdata_next = {4'h0, irq_mask_reg};
         end
         default: begin
            rdata_next = '0;
         end
      endcase
   end

   // Data stand only in the cycle after the read strobe
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rdata_reg <= '0;
      end else if (rd_in) begin
         rdata_reg <= rdata_next;
      end else begin
         rdata_reg <= '0;
      end
   end

   assign rdata_out = rdata_reg;
endmodule // cdm_top
